// *** hw/wads_pkg.sv ***
// package: constants, register map and state types of the wake-up and domain sequencer
package wads_pkg;

    // ****************************************************************
    // register map (word index on the plain register port)
    // ****************************************************************
    localparam logic [4:0] ADDR_EVENT_PEND = 5'h00;
    localparam logic [4:0] ADDR_EVENT_MASK = 5'h01;
    localparam logic [4:0] ADDR_PIN_WAKE_EN = 5'h02;
    localparam logic [4:0] ADDR_CONTROL = 5'h03;
    localparam logic [4:0] ADDR_POINTERS = 5'h04;
    localparam logic [4:0] ADDR_STATUS = 5'h05;
    localparam logic [4:0] ADDR_KEY_DELAY = 5'h06;
    localparam logic [4:0] ADDR_STEP_TIME = 5'h07;
    localparam logic [4:0] ADDR_WDOG = 5'h08;
    localparam logic [4:0] ADDR_VOLT_A = 5'h09;
    localparam logic [4:0] ADDR_SLOT_BASE = 5'h10;

    // ****************************************************************
    // event bit positions
    // ****************************************************************
    localparam int EVENT_COUNT = 16;
    localparam int EV_SUPPLY = 0;
    localparam int EV_WARN = 1;
    localparam int EV_ALARM = 2;
    localparam int EV_TICK = 3;
    localparam int EV_COMP = 4;
    localparam int EV_BUTTON = 5;
    localparam int EV_CHARGER = 6;
    localparam int EV_OVERCUR = 7;
    localparam int EV_RANGE = 8;
    localparam int EV_TEMP = 9;
    localparam int EV_SEQ_DONE = 10;
    localparam int EV_RAMP_DONE = 11;
    localparam int EV_ADC_DONE = 12;
    localparam int EV_PIN = 13;
    localparam int EV_DOMAIN_PIN = 14;
    localparam int EV_SERIAL = 15;

    localparam logic [15:0] USER_EVENTS = 16'h2060;
    localparam logic [15:0] NO_WAKE_EVENTS = 16'h1C00;

    // control register fields
    localparam int CTL_BASE_EN = 0;
    localparam int CTL_SECOND_EN = 1;
    localparam int CTL_THIRD_EN = 2;
    localparam int CTL_LOCK = 3;
    localparam int CTL_RELOAD = 4;
    localparam int CTL_SUPPRESS = 5;
    localparam int CTL_ALIVE = 6;

    // ****************************************************************
    // sequencer and timing
    // ****************************************************************
    localparam int ID_COUNT = 32;
    localparam int SLOT_W = 4;
    localparam int CLK_MHZ = 100;
    localparam int ACTIVE_HOLD_S = 16;
    localparam longint ACTIVE_HOLD_CYCLES = longint'(ACTIVE_HOLD_S) * CLK_MHZ * 1000000;
    localparam logic [31:0] RESET_STEP_TIME = 32'h0000_3200;
    localparam logic [31:0] RESET_KEY_DELAY = 32'h0000_1000;
    localparam logic [31:0] RESET_WDOG = 32'h0010_0000;
    localparam logic [31:0] RESET_VOLT = 32'h0000_0000;
    localparam logic [31:0] RESET_POINTERS = 32'h0000_0FA3;

    typedef enum logic [2:0] {
        WADS_RESET = 3'b000,
        WADS_RELOAD = 3'b001,
        WADS_HOLD = 3'b010,
        WADS_BASE = 3'b011,
        WADS_SECOND = 3'b100,
        WADS_WAIT_ALIVE = 3'b101,
        WADS_ACTIVE = 3'b110
    } wads_state_e;

    typedef struct packed {
        logic [4:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } wads_bus_s;

    typedef struct packed {
        logic base;
        logic second;
        logic third;
    } wads_domains_s;

    typedef struct packed {
        logic [SLOT_W-1:0] base_end;
        logic [SLOT_W-1:0] second_end;
        logic [SLOT_W-1:0] last_slot;
        logic [SLOT_W-1:0] partial_shutdown_slot;
    } wads_pointers_s;

endpackage

// *** hw/wads_top.sv ***
// wake-up qualification and three-domain power sequencer
//
// What this block does
// - every wake source is tagged user or system and handled per class
// - unmasked button and charger events always start a wake-up
// - a set mask bit stops its event from waking
// - with lock on, button must stay low beyond key delay
// - pin wakes need at least one bit of the pin wake enable register set
// - on wake reload voltages, step timer and, unless suppressed, domain enables
// - after reload pulse host wake and drive slot-0 regulators
// - base domain steps wait for the base domain enable
// - active state only after second domain enable
// - missed watchdog alive in window ends active, back to reset
// - done events interrupt but never wake; others do both
// - button, charger and pin transitions are user; rest are system
// - domain port rising edges give system wake events
// - sequencer has step timer, slot array and four boundary pointers
// - up to 32 identifiers across three domains
// - base domain runs from step 1 to base end
// - second domain to second end, third to last slot
// - reload on each power-down to base transition when enabled
// - suspended system wakes return after 16 s in active
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module wads_top #(
    parameter longint ACTIVE_HOLD = wads_pkg::ACTIVE_HOLD_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [4:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [15:0] event_in,
    input wire logic power_button_input,
    input wire logic base_domain_port,
    input wire logic second_domain_port,
    input wire logic third_domain_port,
    input wire logic restart_suspend,
    input wire logic [31:0] stored_volt_a,
    input wire logic [31:0] stored_step_time,
    input wire logic [2:0] stored_domain_en,
    output logic host_wake_signal,
    output logic interrupt_request_out,
    output logic [31:0] volt_a_out,
    output logic [wads_pkg::ID_COUNT-1:0] id_enable,
    output logic [wads_pkg::SLOT_W-1:0] current_step,
    output logic active_state
);

    // a zero hold would lift the suspension on the first active cycle
    if (ACTIVE_HOLD < 1)
    begin : gen_hold_check
        $error("active hold count must be positive");
    end

    // ****************************************************************
    // state
    // ****************************************************************
    localparam int ID_SLOT_BITS = wads_pkg::ID_COUNT * wads_pkg::SLOT_W;

    typedef struct packed {
        logic [1:0] s_btn;
        logic [1:0] s_base;
        logic [1:0] s_second;
        logic [1:0] s_third;
        logic [1:0] s_susp;
        logic [15:0] ev_meta;
        logic [15:0] s_ev;
        logic [15:0] ev_prev;
        logic dom_prev_base;
        logic dom_prev_second;
        logic dom_prev_third;
        logic [15:0] pend;
        logic [15:0] mask;
        logic [15:0] pin_wake_en;
        logic [6:0] ctl;
        wads_pkg::wads_domains_s stored_en;
        wads_pkg::wads_pointers_s ptr;
        logic [31:0] key_delay;
        logic [31:0] key_cnt;
        logic key_ok;
        logic [31:0] step_time;
        logic [31:0] step_cnt;
        logic [31:0] wdog_win;
        logic [31:0] wdog_cnt;
        logic [31:0] volt;
        logic [63:0] hold_cnt;
        logic suspended;
        logic [ID_SLOT_BITS-1:0] slots;
        wads_pkg::wads_state_e st;
        logic [31:0] rdata;
        logic wake_out;
        logic irq;
        logic [wads_pkg::ID_COUNT-1:0] ids;
        logic [wads_pkg::SLOT_W-1:0] step;
        logic active;
    } wads_state_s;

    wads_state_s state_reg;
    wads_state_s state_next;

    function automatic logic [wads_pkg::SLOT_W-1:0] slot_of(
        input logic [ID_SLOT_BITS-1:0] slots,
        input int idx
    );
        slot_of = slots[idx*wads_pkg::SLOT_W +: wads_pkg::SLOT_W];
    endfunction

    // slot words past the id table would index beyond the slot vector
    function automatic logic in_slot_table(input logic [4:0] a);
        in_slot_table = a >= wads_pkg::ADDR_SLOT_BASE
            && a < wads_pkg::ADDR_SLOT_BASE + 5'(ID_SLOT_BITS / 16);
    endfunction

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    logic [15:0] rise;
    logic [15:0] wake_ok;
    logic user_wake;
    logic sys_wake;
    logic wake;
    wads_pkg::wads_domains_s eff;
    logic key_low;
    logic step_tick;
    logic [wads_pkg::SLOT_W-1:0] slot_one;

    always_comb
    begin
        state_next = state_reg;
        state_next.s_btn = {state_reg.s_btn[0], power_button_input};
        state_next.s_base = {state_reg.s_base[0], base_domain_port};
        state_next.s_second = {state_reg.s_second[0], second_domain_port};
        state_next.s_third = {state_reg.s_third[0], third_domain_port};
        state_next.s_susp = {state_reg.s_susp[0], restart_suspend};
        // event sources sit in other domains: two stages before the edge detector
        state_next.ev_meta = event_in;
        state_next.s_ev = state_reg.ev_meta;
        state_next.ev_prev = state_reg.s_ev;
        state_next.dom_prev_base = state_reg.s_base[1];
        state_next.dom_prev_second = state_reg.s_second[1];
        state_next.dom_prev_third = state_reg.s_third[1];
        slot_one = wads_pkg::SLOT_W'(1);

        rise = state_reg.s_ev & ~state_reg.ev_prev;
        // domain port edges arrive as a system-class pin event
        rise[wads_pkg::EV_DOMAIN_PIN] = rise[wads_pkg::EV_DOMAIN_PIN]
            | (state_reg.s_base[1] & ~state_reg.dom_prev_base)
            | (state_reg.s_second[1] & ~state_reg.dom_prev_second)
            | (state_reg.s_third[1] & ~state_reg.dom_prev_third);

        // button is active low and timed by the lock delay
        key_low = ~state_reg.s_btn[1];
        state_next.key_cnt = key_low ? state_reg.key_cnt + 32'h0000_0001 : 32'h0000_0000;
        state_next.key_ok = key_low && (state_reg.key_cnt > state_reg.key_delay);
        if (state_reg.ctl[wads_pkg::CTL_LOCK])
            rise[wads_pkg::EV_BUTTON] = state_next.key_ok & ~state_reg.key_ok;
        else
            rise[wads_pkg::EV_BUTTON] = key_low & (state_reg.key_cnt == 32'h0000_0000);

        wake_ok = rise & ~state_reg.mask & ~wads_pkg::NO_WAKE_EVENTS;
        wake_ok[wads_pkg::EV_PIN] = wake_ok[wads_pkg::EV_PIN]
            & |state_reg.pin_wake_en;
        user_wake = |(wake_ok & wads_pkg::USER_EVENTS);
        sys_wake = |(wake_ok & ~wads_pkg::USER_EVENTS) & ~state_reg.suspended;
        wake = user_wake | sys_wake;

        eff.base = state_reg.s_base[1] | state_reg.ctl[wads_pkg::CTL_BASE_EN]
            | state_reg.stored_en.base;
        eff.second = state_reg.s_second[1] | state_reg.ctl[wads_pkg::CTL_SECOND_EN]
            | state_reg.stored_en.second;
        eff.third = state_reg.s_third[1] | state_reg.ctl[wads_pkg::CTL_THIRD_EN]
            | state_reg.stored_en.third;

        // registers: write side; a hardware set beats a software clear
        if (reg_wr)
        begin
            unique case (reg_addr)
                wads_pkg::ADDR_EVENT_PEND: state_next.pend = state_reg.pend & ~reg_wdata[15:0];
                wads_pkg::ADDR_EVENT_MASK: state_next.mask = reg_wdata[15:0];
                wads_pkg::ADDR_PIN_WAKE_EN: state_next.pin_wake_en = reg_wdata[15:0];
                wads_pkg::ADDR_CONTROL: state_next.ctl = reg_wdata[6:0];
                wads_pkg::ADDR_POINTERS: state_next.ptr = reg_wdata[15:0];
                wads_pkg::ADDR_KEY_DELAY: state_next.key_delay = reg_wdata;
                wads_pkg::ADDR_STEP_TIME: state_next.step_time = reg_wdata;
                wads_pkg::ADDR_WDOG: state_next.wdog_win = reg_wdata;
                wads_pkg::ADDR_VOLT_A: state_next.volt = reg_wdata;
                default:
                begin
                    if (in_slot_table(reg_addr))
                        state_next.slots[(reg_addr - wads_pkg::ADDR_SLOT_BASE) * 16 +: 16]
                            = reg_wdata[15:0];
                end
            endcase
        end
        state_next.pend = state_next.pend | rise;

        state_next.rdata = 32'h0000_0000;
        if (reg_rd)
        begin
            unique case (reg_addr)
                wads_pkg::ADDR_EVENT_PEND: state_next.rdata = {16'h0000, state_reg.pend};
                wads_pkg::ADDR_EVENT_MASK: state_next.rdata = {16'h0000, state_reg.mask};
                wads_pkg::ADDR_PIN_WAKE_EN: state_next.rdata = {16'h0000, state_reg.pin_wake_en};
                wads_pkg::ADDR_CONTROL: state_next.rdata = {25'h000_0000, state_reg.ctl};
                wads_pkg::ADDR_POINTERS: state_next.rdata = {16'h0000, state_reg.ptr};
                wads_pkg::ADDR_STATUS: state_next.rdata = {21'h00_0000, state_reg.suspended,
                    eff, state_reg.step, state_reg.st};
                wads_pkg::ADDR_KEY_DELAY: state_next.rdata = state_reg.key_delay;
                wads_pkg::ADDR_STEP_TIME: state_next.rdata = state_reg.step_time;
                wads_pkg::ADDR_WDOG: state_next.rdata = state_reg.wdog_win;
                wads_pkg::ADDR_VOLT_A: state_next.rdata = state_reg.volt;
                default:
                begin
                    if (in_slot_table(reg_addr))
                        state_next.rdata = {16'h0000,
                            state_reg.slots[(reg_addr - wads_pkg::ADDR_SLOT_BASE) * 16 +: 16]};
                end
            endcase
        end

        state_next.irq = |(state_reg.pend & ~state_reg.mask);

        // suspension of system wakes clears after a long stay in active
        if (state_reg.s_susp[1])
            state_next.suspended = 1'b1;
        if (state_reg.st == wads_pkg::WADS_ACTIVE)
        begin
            state_next.hold_cnt = state_reg.hold_cnt + 64'h0000_0000_0000_0001;
            if (state_reg.hold_cnt >= 64'(ACTIVE_HOLD))
                state_next.suspended = 1'b0;
        end
        else
            state_next.hold_cnt = 64'h0000_0000_0000_0000;

        // step timer paces the slot walk
        step_tick = state_reg.step_cnt >= state_reg.step_time;
        state_next.step_cnt = step_tick ? 32'h0000_0000 : state_reg.step_cnt + 32'h0000_0001;
        state_next.wake_out = 1'b0;

        unique case (state_reg.st)
            wads_pkg::WADS_RESET:
            begin
                state_next.step = '0;
                if (wake)
                    state_next.st = wads_pkg::WADS_RELOAD;
            end
            wads_pkg::WADS_RELOAD:
            begin
                if (state_reg.ctl[wads_pkg::CTL_RELOAD])
                begin
                    state_next.volt = stored_volt_a;
                    state_next.step_time = stored_step_time;
                    if (!state_reg.ctl[wads_pkg::CTL_SUPPRESS])
                        state_next.stored_en = stored_domain_en;
                end
                state_next.wake_out = 1'b1;
                for (int i = 0; i < wads_pkg::ID_COUNT; i++)
                    if (slot_of(state_reg.slots, i) == '0)
                        state_next.ids[i] = 1'b1;
                state_next.st = wads_pkg::WADS_HOLD;
            end
            wads_pkg::WADS_HOLD:
            begin
                // limitation: a held base enable starts at once, any wake is implied
                if (eff.base)
                begin
                    state_next.step = slot_one;
                    state_next.step_cnt = 32'h0000_0000;
                    state_next.st = wads_pkg::WADS_BASE;
                end
            end
            wads_pkg::WADS_BASE:
            begin
                if (step_tick)
                begin
                    for (int i = 0; i < wads_pkg::ID_COUNT; i++)
                        if (slot_of(state_reg.slots, i) == state_reg.step)
                            state_next.ids[i] = 1'b1;
                    if (state_reg.step >= state_reg.ptr.base_end)
                        state_next.st = wads_pkg::WADS_SECOND;
                    else
                        state_next.step = state_reg.step + slot_one;
                end
            end
            wads_pkg::WADS_SECOND:
            begin
                if (eff.second && step_tick)
                begin
                    if (state_reg.step < state_reg.ptr.second_end)
                    begin
                        state_next.step = state_reg.step + slot_one;
                        for (int i = 0; i < wads_pkg::ID_COUNT; i++)
                            if (slot_of(state_reg.slots, i) == state_next.step)
                                state_next.ids[i] = 1'b1;
                    end
                    else
                    begin
                        state_next.wdog_cnt = 32'h0000_0000;
                        state_next.st = wads_pkg::WADS_WAIT_ALIVE;
                    end
                end
            end
            wads_pkg::WADS_WAIT_ALIVE, wads_pkg::WADS_ACTIVE:
            begin
                state_next.wdog_cnt = state_reg.wdog_cnt + 32'h0000_0001;
                if (state_reg.ctl[wads_pkg::CTL_ALIVE])
                begin
                    state_next.ctl[wads_pkg::CTL_ALIVE] = 1'b0;
                    state_next.wdog_cnt = 32'h0000_0000;
                    state_next.st = wads_pkg::WADS_ACTIVE;
                end
                else if (state_reg.wdog_cnt >= state_reg.wdog_win)
                begin
                    state_next.ids = '0;
                    state_next.stored_en = '0;
                    state_next.st = wads_pkg::WADS_RESET;
                end
                // third domain walks on while active
                if (state_reg.st == wads_pkg::WADS_ACTIVE && eff.third && step_tick
                    && state_reg.step < state_reg.ptr.last_slot)
                begin
                    state_next.step = state_reg.step + slot_one;
                    for (int i = 0; i < wads_pkg::ID_COUNT; i++)
                        if (slot_of(state_reg.slots, i) == state_next.step)
                            state_next.ids[i] = 1'b1;
                end
            end
            default:
                state_next.st = wads_pkg::WADS_RESET;
        endcase
        state_next.active = state_next.st == wads_pkg::WADS_ACTIVE;
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= '0;
            state_reg.s_btn <= 2'h3;
            state_reg.key_delay <= wads_pkg::RESET_KEY_DELAY;
            state_reg.step_time <= wads_pkg::RESET_STEP_TIME;
            state_reg.wdog_win <= wads_pkg::RESET_WDOG;
            state_reg.volt <= wads_pkg::RESET_VOLT;
            state_reg.ptr <= wads_pkg::RESET_POINTERS[15:0];
            state_reg.slots <= {ID_SLOT_BITS{1'b1}};
            state_reg.st <= wads_pkg::WADS_RESET;
        end
        else
            state_reg <= state_next;
    end

    assign reg_rdata = state_reg.rdata;
    assign host_wake_signal = state_reg.wake_out;
    assign interrupt_request_out = state_reg.irq;
    assign volt_a_out = state_reg.volt;
    assign id_enable = state_reg.ids;
    assign current_step = state_reg.step;
    assign active_state = state_reg.active;

endmodule // wads_top

`default_nettype wire

// *** verification/wads_host_model.sv ***
// host model: raises the base and second domain enable ports some time after a wake-up; third stays low
`timescale 1ns/1ps
`default_nettype none

module wads_host_model #(
    parameter int DELAY = 60
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic host_wake_signal,
    output logic base_domain_port,
    output logic second_domain_port,
    output logic third_domain_port
);
    int cnt;
    logic armed;

    // slow host: the sequencer must sit in hold until the base enable shows
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt <= 0;
            armed <= 1'b0;
            base_domain_port <= 1'b0;
            second_domain_port <= 1'b0;
            third_domain_port <= 1'b0;
        end
        else
        begin
            if (host_wake_signal)
                armed <= 1'b1;
            if (armed && cnt < DELAY + 20)
                cnt <= cnt + 1;
            base_domain_port <= armed && cnt >= DELAY;
            second_domain_port <= armed && cnt >= DELAY + 20;
            third_domain_port <= 1'b0;
        end
    end
endmodule // wads_host_model
`default_nettype wire

// *** verification/wads_sva.sv ***
// checker: port-level properties of the wake-up and domain sequencer
`timescale 1ns/1ps
`default_nettype none

module wads_sva #(
    parameter longint ACTIVE_HOLD = 50
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic reg_wr,
    input wire logic host_wake_signal,
    input wire logic interrupt_request_out,
    input wire logic [31:0] volt_a_out,
    input wire logic [wads_pkg::ID_COUNT-1:0] id_enable,
    input wire logic [wads_pkg::SLOT_W-1:0] current_step,
    input wire logic active_state
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    wake_one_cycle_a: assert property (host_wake_signal |=> !host_wake_signal)
        else $error("host wake longer than one cycle");
    wake_slot_zero_a: assert property (host_wake_signal |-> current_step == '0)
        else $error("host wake outside slot zero");
    wake_not_active_a: assert property (host_wake_signal |-> !active_state)
        else $error("host wake while active");
    hold_after_wake_a: assert property (host_wake_signal |-> ##1 !active_state [*4])
        else $error("active too soon after wake");
    active_alive_a: assert property ($rose(active_state) |->
        $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
        else $error("active without alive write");
    drop_clears_a: assert property ($fell(active_state) |-> ##[0:2] id_enable == '0)
        else $error("ids left on after leaving active");
    volt_cause_a: assert property ($changed(volt_a_out) |-> host_wake_signal
        || $past(host_wake_signal) || $past(reg_wr) || $past(reg_wr, 2))
        else $error("voltage set changed without reload or write");
    irq_clear_a: assert property ($fell(interrupt_request_out) |->
        $past(reg_wr) || $past(reg_wr, 2))
        else $error("interrupt dropped without a write");
endmodule // wads_sva

bind wads_top wads_sva #(.ACTIVE_HOLD(ACTIVE_HOLD)) wads_sva_inst (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .reg_wr(reg_wr),
    .host_wake_signal(host_wake_signal),
    .interrupt_request_out(interrupt_request_out),
    .volt_a_out(volt_a_out),
    .id_enable(id_enable),
    .current_step(current_step),
    .active_state(active_state)
);
`default_nettype wire

// *** verification/wads_test.sv ***
// testbench: wake qualification and domain sequencing scenarios
`timescale 1ns/1ps
`default_nettype none

module wads_test;
    localparam logic [31:0] VOLT = 32'h1234_5678;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] event_in = 16'h0000;
    logic power_button_input = 1'b1;
    logic [31:0] reg_rdata;
    logic base_p;
    logic second_p;
    logic third_p;
    logic wake;
    logic irq;
    logic [31:0] volt;
    logic [31:0] ids;
    logic [3:0] step;
    logic active;
    logic [31:0] d;
    logic seen;
    logic susp = 1'b0;
    int n_errors = 0;
    int n_compared = 0;

    wads_top #(.ACTIVE_HOLD(50)) wads_top_inst (.ref_clk(ref_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .event_in(event_in), .power_button_input(power_button_input),
        .base_domain_port(base_p), .second_domain_port(second_p),
        .third_domain_port(third_p), .restart_suspend(susp), .stored_volt_a(VOLT),
        .stored_step_time(32'h0000_0004), .stored_domain_en(3'b000),
        .host_wake_signal(wake), .interrupt_request_out(irq), .volt_a_out(volt),
        .id_enable(ids), .current_step(step), .active_state(active));
    wads_host_model wads_host_model_inst (.ref_clk(ref_clk), .reset_n(reset_n),
        .host_wake_signal(wake), .base_domain_port(base_p),
        .second_domain_port(second_p), .third_domain_port(third_p));

    initial forever #5 ref_clk = ~ref_clk;

    // ****************************************************************
    // bus and comparison tasks
    // ****************************************************************
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic watch(input int n);
        seen = 1'b0;
        repeat (n)
        begin
            @(posedge ref_clk);
            #1;
            seen = seen | wake;
        end
    endtask
    task automatic press(input int n);
        logic s;
        @(posedge ref_clk);
        power_button_input <= 1'b0;
        watch(n);
        s = seen;
        @(posedge ref_clk);
        power_button_input <= 1'b1;
        watch(8);
        seen = seen | s;
    endtask
    task automatic pulse(input int b);
        @(posedge ref_clk);
        event_in[b] <= 1'b1;
        watch(8);
        @(posedge ref_clk);
        event_in[b] <= 1'b0;
    endtask
    task automatic wait_state(input logic [2:0] st);
        int i;
        i = 0;
        rd(wads_pkg::ADDR_STATUS);
        while (d[2:0] !== st && i < 200)
        begin
            rd(wads_pkg::ADDR_STATUS);
            i++;
        end
    endtask
    task automatic results;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        results();
    end

    initial
    begin
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(wads_pkg::ADDR_POINTERS);
        check(d, 32'h0000_0FA3);
        wr(wads_pkg::ADDR_EVENT_MASK, 32'h0000_0040);
        pulse(wads_pkg::EV_CHARGER);
        check(32'(seen), 32'h0);
        rd(wads_pkg::ADDR_EVENT_PEND);
        check(d, 32'h0000_0040);
        check(32'(irq), 32'h0);
        wr(wads_pkg::ADDR_EVENT_MASK, 32'h0000_0000);
        wr(wads_pkg::ADDR_EVENT_PEND, 32'h0000_0040);
        pulse(wads_pkg::EV_SEQ_DONE);
        check(32'(seen), 32'h0);
        check(32'(irq), 32'h1);
        wr(wads_pkg::ADDR_EVENT_PEND, 32'h0000_0400);
        repeat (2) @(posedge ref_clk);
        #1;
        check(32'(irq), 32'h0);
        // system sources are left unmasked; ordering base < second < last
        wr(wads_pkg::ADDR_POINTERS, 32'h0000_2560);
        wr(wads_pkg::ADDR_WDOG, 32'h0000_012C);
        wr(wads_pkg::ADDR_KEY_DELAY, 32'h0000_0014);
        wr(wads_pkg::ADDR_CONTROL, 32'h0000_0018);
        wr(wads_pkg::ADDR_SLOT_BASE, 32'h0000_3210);
        press(6);
        check(32'(seen), 32'h0);
        press(40);
        check(32'(seen), 32'h1);
        check(volt, VOLT);
        rd(wads_pkg::ADDR_STATUS);
        check(32'(d[2:0]), 32'(wads_pkg::WADS_HOLD));
        wait_state(wads_pkg::WADS_WAIT_ALIVE);
        check(32'(step), 32'h0000_0005);
        check(ids, 32'h0000_000F);
        rd(wads_pkg::ADDR_EVENT_PEND);
        check(32'(d[wads_pkg::EV_DOMAIN_PIN]), 32'h1);
        repeat (400) @(posedge ref_clk);
        susp <= 1'b1;
        #1;
        check(32'(active), 32'h0);
        check(ids, 32'h0000_0000);
        pulse(wads_pkg::EV_ALARM);
        check(32'(seen), 32'h0);
        pulse(wads_pkg::EV_CHARGER);
        check(32'(seen), 32'h1);
        wait_state(wads_pkg::WADS_WAIT_ALIVE);
        wr(wads_pkg::ADDR_CONTROL, 32'h0000_0058);
        repeat (3) @(posedge ref_clk);
        #1;
        check(32'(active), 32'h1);
        repeat (60) @(posedge ref_clk);
        rd(wads_pkg::ADDR_STATUS);
        check(32'(d[10]), 32'h0);
        repeat (400) @(posedge ref_clk);
        #1;
        check(32'(active), 32'h0);
        results();
    end
endmodule // wads_test
`default_nettype wire
